/* File: logic/exc_pkg.sv */
// constants, vectors and state encoding for the exception unit
package exc_pkg;
    // vector numbers from the standard vector table
    localparam logic [7:0] VEC_RESET     = 8'h00;
    localparam logic [7:0] VEC_BUS       = 8'h02;
    localparam logic [7:0] VEC_ADDR      = 8'h03;
    localparam logic [7:0] VEC_ILLEGAL   = 8'h04;
    localparam logic [7:0] VEC_ZERO_DIV  = 8'h05;
    localparam logic [7:0] VEC_BOUNDS    = 8'h06;
    localparam logic [7:0] VEC_OVF       = 8'h07;
    localparam logic [7:0] VEC_PRIV      = 8'h08;
    localparam logic [7:0] VEC_TRACE     = 8'h09;
    localparam logic [7:0] VEC_LINE_A    = 8'h0A;
    localparam logic [7:0] VEC_LINE_F    = 8'h0B;
    localparam logic [7:0] VEC_TRAP_BASE = 8'h20;

    // status register layout
    localparam int          SR_T     = 15;
    localparam int          SR_S     = 13;
    localparam logic [15:0] SR_RESET = 16'h2700;

    // opcode patterns
    localparam logic [15:0] OP_ILL_SYS0   = 16'h4AFA;
    localparam logic [15:0] OP_ILL_SYS1   = 16'h4AFB;
    localparam logic [15:0] OP_ILL_USER   = 16'h4AFC;
    localparam logic [3:0]  OP_LINE_A     = 4'hA;
    localparam logic [3:0]  OP_LINE_F     = 4'hF;
    localparam logic [15:0] OP_STOP       = 16'h4E72;
    localparam logic [15:0] OP_EXT_RESET  = 16'h4E70;
    localparam logic [15:0] OP_RTE        = 16'h4E73;
    localparam logic [15:0] OP_ANDI_SR    = 16'h027C;
    localparam logic [15:0] OP_EORI_SR    = 16'h0A7C;
    localparam logic [15:0] OP_ORI_SR     = 16'h007C;
    localparam logic [15:0] OP_SR_MOVE    = 16'h46C0;
    localparam logic [15:0] MASK_SR_MOVE  = 16'hFFC0;
    localparam logic [15:0] OP_USP_MOVE   = 16'h4E60;
    localparam logic [15:0] MASK_USP_MOVE = 16'hFFF0;

    // register indices on the plain port
    localparam logic [3:0] REG_SR    = 4'h0;
    localparam logic [3:0] REG_STATE = 4'h1;
    localparam logic [3:0] REG_FRAME = 4'h8;

    // group-0 frame, lowest stack address first
    localparam int FRAME_WORDS = 7;
    localparam int FR_STATUS   = 0;
    localparam int FR_ADDR_HI  = 1;
    localparam int FR_ADDR_LO  = 2;
    localparam int FR_IR       = 3;
    localparam int FR_SR       = 4;
    localparam int FR_PC_HI    = 5;
    localparam int FR_PC_LO    = 6;
    localparam int FS_RW       = 4;
    localparam int FS_IN       = 3;

    // stacked pc advance range in words
    localparam logic [2:0] PC_ADV_MIN = 3'h1;
    localparam logic [2:0] PC_ADV_MAX = 3'h5;

    typedef enum logic [4:0] {
        ST_NORMAL = 5'b00001,
        ST_G2     = 5'b00010,
        ST_G1     = 5'b00100,
        ST_G0     = 5'b01000,
        ST_HALT   = 5'b10000
    } proc_state_e;
endpackage

/* File: logic/trap_trace_fault_exception_unit.sv */
// exception detection and sequencing for the 16-bit core
//
// Overview of operation
// (RULE1) software trap always raises an exception
// (RULE2) overflow trap and bounds check raise on failure
// (RULE3) divides with zero divisor raise exception
// (RULE4) opcode not legal takes illegal exception
// (RULE5) three fixed opcodes always decode illegal
// (RULE6) top nibble A or F: own vectors
// (RULE7) privileged instructions in user state violate privilege
// (RULE8) trace set at start traps after completion
// (RULE9) no trace for instructions never executed
// (RULE10) trace processed before a pending interrupt
// (RULE11) forced exception processed before trace
// (RULE12) bus error aborts cycle and processing at once
// (RULE13) bus error entry: copy sr, supervisor, trace off
// (RULE14) stacked pc advanced one to five words
// (RULE15) frame holds opcode word and fault address
// (RULE16) frame holds direction, instruction flag, function code
// (RULE17) instruction flag clear in group 0/1 processing
// (RULE18) fetch resumes through vector two
// (RULE19) fault during group-0 processing halts processor
// (RULE20) only reset releases the halt
// (RULE21) odd word access raises address error, aborted
// (RULE22) address error uses bus frame, own vector
// (RULE23) address error runs short cycle then exception
// (RULE24) reset, address, bus; group 0, 1, 2
// (RULE25) group 0 within two clocks, group 1 between; here a bus error starts four clocks after the pin falls
// (RULE26) standard vector numbers and frame word order
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
module trap_trace_fault_exception_unit #(
    parameter int ADDR_W = 24
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    // instruction start from the sequencer
    input  wire logic              instr_start,
    input  wire logic [15:0]       opcode,
    input  wire logic              opcode_legal,
    input  wire logic [ADDR_W-1:0] instr_addr,
    output logic                   instr_suppress,
    // instruction completion with forced conditions
    input  wire logic              instr_done,
    input  wire logic              soft_trap_op,
    input  wire logic [3:0]        trap_number,
    input  wire logic              overflow_trap_op,
    input  wire logic              overflow_flag,
    input  wire logic              bounds_check_op,
    input  wire logic              bounds_violation,
    input  wire logic              signed_divide_op,
    input  wire logic              unsigned_divide_op,
    input  wire logic              divisor_zero,
    // interrupt pending between instructions
    input  wire logic              irq_pending,
    input  wire logic [7:0]        irq_vector,
    // bus access in progress
    input  wire logic              acc_valid,
    input  wire logic [ADDR_W-1:0] acc_addr,
    input  wire logic              acc_word,
    input  wire logic              acc_write,
    input  wire logic [2:0]        acc_fc,
    input  wire logic [2:0]        pc_advance,
    input  wire logic              bus_error_n,
    output logic                   abort_cycle,
    output logic                   short_cycle,
    // exception handshake towards the sequencer
    output logic                   exc_req,
    output logic                   g0_start,
    output logic      [7:0]        exc_vector,
    input  wire logic              exc_ack,
    input  wire logic              exc_done,
    // status
    output logic      [15:0]       sr_out,
    output logic      [15:0]       saved_sr,
    output logic                   instr_flag,
    output logic                   halted
);
    initial begin
        if (ADDR_W < 17 || ADDR_W > 32) begin
            $error("address width must lie between 17 and 32");
        end
    end

    exc_pkg::proc_state_e state_ff;
    logic [15:0] sr_ff;
    logic [15:0] saved_sr_ff;
    logic [15:0] ir_ff;
    logic [ADDR_W-1:0] pc_base_ff;
    logic [15:0] frame_ff [exc_pkg::FRAME_WORDS];
    logic        pend_g2_ff, pend_trace_ff, pend_g1_ff;
    logic [7:0]  g2_vec_ff, g1_vec_ff;
    logic        trace_arm_ff, in_instr_ff;
    logic        req_ff, g0_start_ff;
    logic [7:0]  vec_ff;
    logic [15:0] rdata_ff;
    logic        berr1_ff, berr2_ff, berr3_ff, berr_lvl_ff;
    logic        addr_err, berr_evt, g0_hit, live, double_fault;
    logic        priv_op, line_hit, fixed_ill, g1_hit, g2_hit;
    logic [7:0]  g1_vec, g2_vec, sel_vec;
    logic        sel_any;
    logic [2:0]  adv;
    logic [ADDR_W-1:0] fault_pc;
    logic [31:0] acc_addr_w, fault_pc_w;

    // bus error pin: three flops, counted once the last two agree
    always_ff @(posedge clk) begin
        if (rst) begin
            berr1_ff    <= 1'b0;
            berr2_ff    <= 1'b0;
            berr3_ff    <= 1'b0;
            berr_lvl_ff <= 1'b0;
        end else begin
            berr1_ff <= ~bus_error_n;
            berr2_ff <= berr1_ff;
            berr3_ff <= berr2_ff;
            if (berr2_ff == berr3_ff) begin
                berr_lvl_ff <= berr3_ff;
            end
        end
    end

    // group-0 detection; address error outranks bus error
    assign live         = (state_ff != exc_pkg::ST_HALT);
    assign addr_err     = live & acc_valid & acc_word & acc_addr[0];           // [RULE21]
    assign berr_evt     = live & berr2_ff & berr3_ff & ~berr_lvl_ff;           // [RULE12]
    assign g0_hit       = addr_err | berr_evt;
    assign double_fault = g0_hit & (state_ff == exc_pkg::ST_G0);              // [RULE19]
    assign abort_cycle  = g0_hit;                                              // [RULE12] [RULE21]
    assign short_cycle  = addr_err;                                            // [RULE23]

    // opcode decode at instruction start
    always_comb begin
        priv_op = (opcode == exc_pkg::OP_STOP) || (opcode == exc_pkg::OP_EXT_RESET)
               || (opcode == exc_pkg::OP_RTE) || (opcode == exc_pkg::OP_ANDI_SR)
               || (opcode == exc_pkg::OP_EORI_SR) || (opcode == exc_pkg::OP_ORI_SR)
               || ((opcode & exc_pkg::MASK_SR_MOVE) == exc_pkg::OP_SR_MOVE)
               || ((opcode & exc_pkg::MASK_USP_MOVE) == exc_pkg::OP_USP_MOVE); // [RULE7]
        line_hit  = (opcode[15:12] == exc_pkg::OP_LINE_A)
                 || (opcode[15:12] == exc_pkg::OP_LINE_F);
        fixed_ill = (opcode == exc_pkg::OP_ILL_SYS0) || (opcode == exc_pkg::OP_ILL_SYS1)
                 || (opcode == exc_pkg::OP_ILL_USER);                          // [RULE5]
        g1_hit = line_hit | fixed_ill | ~opcode_legal | (priv_op & ~sr_ff[exc_pkg::SR_S]);
        if (opcode[15:12] == exc_pkg::OP_LINE_A) begin
            g1_vec = exc_pkg::VEC_LINE_A;                                      // [RULE6]
        end else if (opcode[15:12] == exc_pkg::OP_LINE_F) begin
            g1_vec = exc_pkg::VEC_LINE_F;                                      // [RULE6]
        end else if (fixed_ill || !opcode_legal) begin
            g1_vec = exc_pkg::VEC_ILLEGAL;                                     // [RULE4]
        end else begin
            g1_vec = exc_pkg::VEC_PRIV;                                        // [RULE7]
        end
    end
    // the sequencer must not execute what decodes as a group-1 fault
    assign instr_suppress = instr_start & g1_hit;

    // forced exceptions at completion
    always_comb begin
        g2_hit = soft_trap_op | (overflow_trap_op & overflow_flag)
              | (bounds_check_op & bounds_violation)
              | ((signed_divide_op | unsigned_divide_op) & divisor_zero);
        if (soft_trap_op) begin
            g2_vec = exc_pkg::VEC_TRAP_BASE | {4'h0, trap_number};             // [RULE1]
        end else if (overflow_trap_op && overflow_flag) begin
            g2_vec = exc_pkg::VEC_OVF;                                         // [RULE2]
        end else if (bounds_check_op && bounds_violation) begin
            g2_vec = exc_pkg::VEC_BOUNDS;                                      // [RULE2]
        end else begin
            g2_vec = exc_pkg::VEC_ZERO_DIV;                                    // [RULE3]
        end
    end

    // pick the next pending exception: forced, trace, interrupt, decode fault
    always_comb begin
        sel_any = 1'b1;
        if (pend_g2_ff) begin
            sel_vec = g2_vec_ff;                                               // [RULE11]
        end else if (pend_trace_ff) begin
            sel_vec = exc_pkg::VEC_TRACE;                                      // [RULE10]
        end else if (irq_pending && !in_instr_ff) begin
            sel_vec = irq_vector;
        end else if (pend_g1_ff) begin
            sel_vec = g1_vec_ff;
        end else begin
            sel_vec = exc_pkg::VEC_RESET;
            sel_any = 1'b0;
        end
    end

    // stacked pc: clamp the sequencer's advance to the documented span
    always_comb begin
        if (pc_advance < exc_pkg::PC_ADV_MIN) begin
            adv = exc_pkg::PC_ADV_MIN;
        end else if (pc_advance > exc_pkg::PC_ADV_MAX) begin
            adv = exc_pkg::PC_ADV_MAX;
        end else begin
            adv = pc_advance;
        end
        fault_pc   = pc_base_ff + ADDR_W'({adv, 1'b0});                        // [RULE14]
        acc_addr_w = 32'(acc_addr);
        fault_pc_w = 32'(fault_pc);
    end

    // instruction tracking and trace arming; decode faults never arm trace
    always_ff @(posedge clk) begin
        if (rst) begin
            ir_ff        <= 16'h0000;
            pc_base_ff   <= '0;
            trace_arm_ff <= 1'b0;
            in_instr_ff  <= 1'b0;
        end else if (g0_hit) begin
            trace_arm_ff <= 1'b0;
            in_instr_ff  <= 1'b0;
        end else if (instr_start) begin
            ir_ff        <= opcode;
            pc_base_ff   <= instr_addr;
            trace_arm_ff <= sr_ff[exc_pkg::SR_T] & ~g1_hit;                   // [RULE8] [RULE9]
            in_instr_ff  <= ~g1_hit;
        end else if (instr_done) begin
            trace_arm_ff <= 1'b0;
            in_instr_ff  <= 1'b0;
        end
    end

    // pending exceptions; a group-0 fault wipes what was in progress
    always_ff @(posedge clk) begin
        if (rst || g0_hit) begin
            pend_g2_ff    <= 1'b0;
            pend_trace_ff <= 1'b0;
            pend_g1_ff    <= 1'b0;
            g2_vec_ff     <= exc_pkg::VEC_RESET;
            g1_vec_ff     <= exc_pkg::VEC_RESET;
        end else begin
            if (instr_start && g1_hit) begin
                pend_g1_ff <= 1'b1;
                g1_vec_ff  <= g1_vec;                                          // [RULE4]
            end else if (exc_ack && req_ff && !pend_g2_ff && !pend_trace_ff
                         && vec_ff == g1_vec_ff) begin
                pend_g1_ff <= 1'b0;
            end
            if (instr_done && in_instr_ff && g2_hit) begin
                pend_g2_ff <= 1'b1;
                g2_vec_ff  <= g2_vec;                                          // [RULE3]
            end else if (exc_ack && req_ff && pend_g2_ff) begin
                pend_g2_ff <= 1'b0;
            end
            if (instr_done && in_instr_ff && trace_arm_ff) begin
                pend_trace_ff <= 1'b1;                                         // [RULE8]
            end else if (exc_ack && req_ff && !pend_g2_ff && pend_trace_ff) begin
                pend_trace_ff <= 1'b0;
            end
        end
    end

    // processing state; group 0 preempts everything, address error on the next clock, bus error four clocks after the pin falls
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff    <= exc_pkg::ST_G0;     // reset processing counts as group 0
            req_ff      <= 1'b0;
            g0_start_ff <= 1'b0;
            vec_ff      <= exc_pkg::VEC_RESET;
        end else begin
            g0_start_ff <= 1'b0;
            case (state_ff)
                exc_pkg::ST_HALT: begin
                    req_ff <= 1'b0;                                            // [RULE20]
                end
                default: begin
                    if (double_fault) begin
                        state_ff <= exc_pkg::ST_HALT;                          // [RULE19]
                        req_ff   <= 1'b0;
                    end else if (g0_hit) begin
                        state_ff    <= exc_pkg::ST_G0;                         // [RULE25]
                        req_ff      <= 1'b0;
                        g0_start_ff <= 1'b1;
                        vec_ff      <= addr_err ? exc_pkg::VEC_ADDR            // [RULE24]
                                                : exc_pkg::VEC_BUS;            // [RULE18] [RULE22]
                    end else if (req_ff && exc_ack) begin
                        req_ff   <= 1'b0;
                        state_ff <= (pend_g2_ff) ? exc_pkg::ST_G2 : exc_pkg::ST_G1;
                    end else if (state_ff != exc_pkg::ST_NORMAL && exc_done) begin
                        state_ff <= exc_pkg::ST_NORMAL;
                    end else if (state_ff == exc_pkg::ST_NORMAL && !req_ff && sel_any) begin
                        req_ff <= 1'b1;                                        // [RULE25]
                        vec_ff <= sel_vec;
                    end
                end
            endcase
        end
    end

    // status register: exception entry wins over a software write
    always_ff @(posedge clk) begin
        if (rst) begin
            sr_ff       <= exc_pkg::SR_RESET;
            saved_sr_ff <= 16'h0000;
        end else if (g0_hit && !double_fault || (req_ff && exc_ack)) begin
            saved_sr_ff              <= sr_ff;                                 // [RULE13]
            sr_ff[exc_pkg::SR_S]     <= 1'b1;
            sr_ff[exc_pkg::SR_T]     <= 1'b0;
        end else if (reg_wr && reg_addr == exc_pkg::REG_SR) begin
            sr_ff <= reg_wdata;
        end
    end

    // group-0 frame captured at the moment of the fault
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < exc_pkg::FRAME_WORDS; i++) begin
                frame_ff[i] <= 16'h0000;
            end
        end else if (g0_hit && !double_fault) begin
            frame_ff[exc_pkg::FR_STATUS] <= {11'h000, ~acc_write,                 // [RULE16]
                ~(state_ff == exc_pkg::ST_NORMAL || state_ff == exc_pkg::ST_G2), // [RULE17]
                acc_fc};
            frame_ff[exc_pkg::FR_ADDR_HI] <= acc_addr_w[31:16];                // [RULE15]
            frame_ff[exc_pkg::FR_ADDR_LO] <= acc_addr_w[15:0];
            frame_ff[exc_pkg::FR_IR]      <= ir_ff;                            // [RULE15]
            frame_ff[exc_pkg::FR_SR]      <= sr_ff;                            // [RULE26]
            frame_ff[exc_pkg::FR_PC_HI]   <= fault_pc_w[31:16];
            frame_ff[exc_pkg::FR_PC_LO]   <= fault_pc_w[15:0];
        end
    end

    // register read: data one cycle after the strobe, zero when unmapped
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr == exc_pkg::REG_SR) begin
                rdata_ff <= sr_ff;
            end else if (reg_addr == exc_pkg::REG_STATE) begin
                rdata_ff <= {3'h0, state_ff, pend_g2_ff, pend_trace_ff, pend_g1_ff,
                             req_ff, trace_arm_ff, in_instr_ff, 2'h0};
            end else if (reg_addr >= exc_pkg::REG_FRAME && reg_addr
                         < exc_pkg::REG_FRAME + 4'(exc_pkg::FRAME_WORDS)) begin
                rdata_ff <= frame_ff[3'(reg_addr - exc_pkg::REG_FRAME)];
            end else begin
                rdata_ff <= 16'h0000;
            end
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

    assign reg_rdata  = rdata_ff;
    assign exc_req    = req_ff;
    assign g0_start   = g0_start_ff;
    assign exc_vector = vec_ff;
    assign sr_out     = sr_ff;
    assign saved_sr   = saved_sr_ff;
    assign halted     = (state_ff == exc_pkg::ST_HALT);
    assign instr_flag = (state_ff == exc_pkg::ST_NORMAL) || (state_ff == exc_pkg::ST_G2);

    // checks kept beside the logic
    sequence addr_fault_s;
        addr_err && state_ff != exc_pkg::ST_G0;
    endsequence
    sequence addr_entry_s;
        g0_start_ff && vec_ff == exc_pkg::VEC_ADDR && sr_ff[exc_pkg::SR_S];
    endsequence

    addr_entry_a: assert property (@(posedge clk) disable iff (rst) // [RULE21] [RULE25]
        addr_fault_s |=> addr_entry_s)
        else $error("address error not entered next cycle");
    bus_entry_a: assert property (@(posedge clk) disable iff (rst) // [RULE13]
        (berr_evt && !addr_err && state_ff != exc_pkg::ST_G0) |=>
        (vec_ff == exc_pkg::VEC_BUS && !sr_ff[exc_pkg::SR_T] && saved_sr_ff == $past(sr_ff)))
        else $error("bus error entry wrong");
    double_halt_a: assert property (@(posedge clk) disable iff (rst) // [RULE19]
        double_fault |=> halted ##1 halted)
        else $error("double fault did not halt");
    halt_sticky_a: assert property (@(posedge clk) disable iff (rst) // [RULE20]
        halted && !rst |=> halted && !exc_req && !g0_start)
        else $error("halt released without reset");
    fixed_illegal_a: assert property (@(posedge clk) disable iff (rst) // [RULE5]
        (instr_start && opcode == exc_pkg::OP_ILL_USER && !g0_hit) |=>
        (pend_g1_ff && g1_vec_ff == exc_pkg::VEC_ILLEGAL && !trace_arm_ff))
        else $error("fixed illegal opcode not trapped");
    user_priv_a: assert property (@(posedge clk) disable iff (rst) // [RULE7]
        (instr_start && opcode == exc_pkg::OP_RTE && !sr_ff[exc_pkg::SR_S] && !g0_hit)
        |-> instr_suppress ##1 (pend_g1_ff && g1_vec_ff == exc_pkg::VEC_PRIV))
        else $error("privilege violation missed");
    zero_div_a: assert property (@(posedge clk) disable iff (rst) // [RULE3]
        (instr_done && in_instr_ff && unsigned_divide_op && divisor_zero
         && !soft_trap_op && !overflow_trap_op && !bounds_check_op && !g0_hit)
        |=> (pend_g2_ff && g2_vec_ff == exc_pkg::VEC_ZERO_DIV))
        else $error("zero divide not trapped");
    forced_first_a: assert property (@(posedge clk) disable iff (rst) // [RULE11]
        (pend_g2_ff && pend_trace_ff && state_ff == exc_pkg::ST_NORMAL
         && !req_ff && !g0_hit) |=> (req_ff && vec_ff == g2_vec_ff))
        else $error("trace issued before forced exception");
    trace_first_a: assert property (@(posedge clk) disable iff (rst) // [RULE10]
        (pend_trace_ff && !pend_g2_ff && irq_pending && state_ff == exc_pkg::ST_NORMAL
         && !req_ff && !g0_hit) |=> (req_ff && vec_ff == exc_pkg::VEC_TRACE))
        else $error("interrupt issued before trace");
    frame_flag_a: assert property (@(posedge clk) disable iff (rst) // [RULE17]
        (g0_hit && state_ff == exc_pkg::ST_G1) |=> frame_ff[exc_pkg::FR_STATUS][exc_pkg::FS_IN])
        else $error("instruction flag wrong in group 1");
endmodule // trap_trace_fault_exception_unit

/* File: sim/bus_fault_model.sv */
// external decoder that flags a bus error for a hole in the map
`timescale 1ns/100ps
module bus_fault_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // access on the bus
    input  wire logic        acc_valid,
    input  wire logic [23:0] acc_addr,
    // bus error pin, active low
    output logic             bus_error_n
);
    // upper half unmapped; registered, so the pin lags one cycle
    always_ff @(posedge clk) begin
        bus_error_n <= rst | ~(acc_valid & acc_addr[23]);
    end
endmodule // bus_fault_model

/* File: sim/tb_trap_trace_fault_exception_unit.sv */
// bench for the exception unit
`timescale 1ns/100ps
`define chk(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected %s exp %h got %h", n, e, a); end end
module tb_trap_trace_fault_exception_unit;
    logic        clk = 0, rst = 1, wr = 0, rdn = 0, st = 0, lg = 0, dn = 0, ip = 0;
    logic        ack = 0, edn = 0, av = 0, aw = 0, sup, abt, shc, req, g0s, ifl, hlt, ben;
    logic [3:0]  ra = 0, tn = 0;
    logic [2:0]  fc = 0;
    logic [7:0]  f = 0, vec;
    logic [15:0] wd = 0, op = 0, rd, sr, ssr;
    logic [23:0] aa = 0;
    int          err_count = 0, checked = 0, cyc_n = 0;
    trap_trace_fault_exception_unit trap_trace_fault_exception_unit_inst (
        .clk(clk), .rst(rst), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rdn),
        .reg_rdata(rd), .instr_start(st), .opcode(op), .opcode_legal(lg),
        .instr_addr(24'h001000), .instr_suppress(sup), .instr_done(dn),
        .soft_trap_op(f[7]), .trap_number(tn), .overflow_trap_op(f[6]),
        .overflow_flag(f[5]), .bounds_check_op(f[4]), .bounds_violation(f[3]),
        .signed_divide_op(f[2]), .unsigned_divide_op(f[1]), .divisor_zero(f[0]),
        .irq_pending(ip), .irq_vector(8'h40), .acc_valid(av), .acc_addr(aa),
        .acc_word(aw), .acc_write(1'b0), .acc_fc(fc), .pc_advance(3'h2),
        .bus_error_n(ben), .abort_cycle(abt), .short_cycle(shc), .exc_req(req),
        .g0_start(g0s), .exc_vector(vec), .exc_ack(ack), .exc_done(edn),
        .sr_out(sr), .saved_sr(ssr), .instr_flag(ifl), .halted(hlt));
    bus_fault_model bus_fault_model_inst (.clk(clk), .rst(rst), .acc_valid(av),
        .acc_addr(aa), .bus_error_n(ben));
    always #4 clk = ~clk;
    // ceiling well above the fewer than two hundred cycles the tests need
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // wait for a request, check the vector, accept and finish it
    task automatic take(input logic [7:0] v);
        for (int i = 0; i < 20 && req !== 1'b1; i++) @(negedge clk);
        `chk("exc_vector", v, vec)
        @(posedge clk) ack <= 1;
        @(posedge clk) ack <= 0;
        edn <= 1;
        @(posedge clk) edn <= 0;
    endtask
    task automatic go(input logic s, input logic d, input logic [15:0] o, input logic [7:0] x);
        @(posedge clk) begin st <= s; dn <= d; op <= o; f <= x; tn <= 4'hC; lg <= 1; end
        @(posedge clk) begin st <= 0; dn <= 0; f <= 0; end
    endtask
    task automatic rrd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk) begin rdn <= 1; ra <= a; wr <= 0; end
        @(posedge clk) rdn <= 0;
        @(negedge clk) `chk("reg_rdata", e, rd & m)
    endtask
    task automatic t_reset();
        `chk("sr_out", 16'h2700, sr)
        `chk("halted", 1'b0, hlt)
        @(posedge clk) edn <= 1;
        @(posedge clk) edn <= 0;
        $display("reset test done");
    endtask
    task automatic t_trap();
        logic [7:0] fs [5] = '{8'h80, 8'h60, 8'h18, 8'h05, 8'h03};
        logic [7:0] vs [5] = '{8'h2C, 8'h07, 8'h06, 8'h05, 8'h05};
        for (int i = 0; i < 5; i++) begin
            go(1, 0, 16'h4E71, 0);
            go(0, 1, 16'h4E71, fs[i]);
            take(vs[i]);
        end
        go(1, 0, 16'h4E71, 0);
        @(posedge clk) begin wr <= 1; ra <= exc_pkg::REG_SR; wd <= 16'hA700; end
        @(posedge clk) wr <= 0;
        go(1, 0, 16'h4E71, 0);
        ip <= 1;
        go(0, 1, 16'h4E71, 8'h80);
        take(8'h2C);
        `chk("saved_sr", 16'hA700, ssr)
        take(exc_pkg::VEC_TRACE);
        take(8'h40);
        ip <= 0;
        `chk("sr_t", 1'b0, sr[15])
        $display("trap and trace test done");
    endtask
    task automatic t_decode();
        logic [15:0] os [7] = '{16'h4AFA, 16'h4AFB, 16'h4AFC, 16'hA123, 16'hF456,
            16'h4AFD, exc_pkg::OP_RTE};
        logic [7:0] vs [7] = '{8'h04, 8'h04, 8'h04, 8'h0A, 8'h0B, 8'h04, 8'h08};
        for (int i = 0; i < 7; i++) begin
            // last entry is privileged, so drop to user state first
            if (i == 6) begin
                wr <= 1;
                wd <= 0;
                rrd(exc_pkg::REG_SR, 16'hFFFF, 16'h0000);
            end
            @(posedge clk) begin st <= 1; op <= os[i]; lg <= (i != 5); end
            @(negedge clk) `chk("instr_suppress", 1'b1, sup)
            @(posedge clk) begin st <= 0; wr <= 0; end
            take(vs[i]);
        end
        rrd(4'h5, 16'hFFFF, 16'h0000);
        $display("decode test done");
    endtask
    task automatic t_fault();
        @(posedge clk) begin av <= 1; aa <= 24'h800100; aw <= 1; fc <= 3'h5; end
        for (int i = 0; i < 20 && g0s !== 1'b1; i++) @(negedge clk);
        `chk("exc_vector", exc_pkg::VEC_BUS, vec)
        @(posedge clk) av <= 0;
        rrd(exc_pkg::REG_FRAME, 16'h001F, 16'h0015);
        rrd(4'hA, 16'hFFFF, 16'h0100);
        `chk("instr_flag", 1'b0, ifl)
        @(posedge clk) edn <= 1;
        @(posedge clk) begin edn <= 0; av <= 1; aa <= 24'h000101; end
        @(negedge clk) `chk("abort_cycle", 1'b1, abt)
        `chk("short_cycle", 1'b1, shc)
        @(posedge clk) begin av <= 0; edn <= 0; end
        @(negedge clk) `chk("g0_start", 1'b1, g0s)
        `chk("exc_vector", exc_pkg::VEC_ADDR, vec)
        @(posedge clk) av <= 1;
        @(posedge clk) av <= 0;
        repeat (4) @(posedge clk);
        `chk("halted", 1'b1, hlt)
        rst <= 1;
        @(posedge clk) rst <= 0;
        @(negedge clk) t_reset();
        $display("fault test done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        @(negedge clk) t_reset();
        t_trap();
        t_decode();
        t_fault();
        end_sim();
    end
endmodule // tb_trap_trace_fault_exception_unit
